/* core/gain_loop_pkg.sv */
// Summary of operation
// - hysteresis code picks dead zone around target
// - skip 8/16/24/32 samples after gain step
// - code 00 free, 01 holds after sync
// - code 10 holds analogue, 11 holds both
// - fsk averaging length 8/16/32/64 samples
// - ook/ask decision boundary 4/8/12/16 dB
package gain_loop_pkg;
   localparam logic [5:0] GAIN_LOOP_CONTROL_0_ADDR = 6'h1d;
   localparam logic [7:0] GAIN_LOOP_CONTROL_0_RESET = 8'h91;
   localparam int HYST_LSB = 6;
   localparam int WAIT_LSB = 4;
   localparam int HOLD_LSB = 2;
   localparam int LEN_LSB = 0;
   localparam logic [1:0] HOLD_NONE = 2'h0;
   localparam logic [1:0] HOLD_SYNC = 2'h1;
   localparam logic [1:0] HOLD_ANALOG = 2'h2;
   localparam logic [1:0] HOLD_BOTH = 2'h3;
   localparam logic [5:0] WAIT_STEP = 6'h08;
   localparam logic [2:0] AVG_SHIFT_BASE = 3'h3;
   localparam logic [2:0] OOK_AVG_SHIFT = 3'h3;
   localparam logic [4:0] BOUNDARY_STEP_DB = 5'h04;
   localparam logic [2:0] GAIN_MAX = 3'h7;
   localparam logic [2:0] GAIN_RESET = 3'h7;
   localparam logic [7:0] DZ_SMALL = 8'h02;
   localparam logic [7:0] DZ_LOW_HIGH = 8'h04;
   localparam logic [7:0] DZ_MED_LOW = 8'h04;
   localparam logic [7:0] DZ_MED_HIGH = 8'h08;
   localparam logic [7:0] DZ_LARGE_LOW = 8'h08;
   localparam logic [7:0] DZ_LARGE_HIGH = 8'h10;

   typedef enum logic [0:0] {
      WIN_SKIP = 1'b0,
      WIN_ACCUM = 1'b1
   } window_state_type;

   function automatic logic [1:0] field2(input logic [7:0] data, input int lsb);
      field2 = data[lsb +: 2];
   endfunction

   function automatic logic [5:0] skip_len_of(input logic [1:0] code);
      skip_len_of = 6'(WAIT_STEP * ({4'h0, code} + 6'h01));
   endfunction

   function automatic logic [2:0] avg_shift_of(input logic [1:0] code);
      avg_shift_of = AVG_SHIFT_BASE + {1'b0, code};
   endfunction

   function automatic logic [4:0] boundary_db_of(input logic [1:0] code);
      boundary_db_of = 5'(BOUNDARY_STEP_DB * ({3'h0, code} + 5'h01));
   endfunction

   // dead zone below target; a wide lower zone makes the loop slow to raise gain
   function automatic logic [7:0] dead_low_of(input logic [1:0] code);
      case (code)
         2'h0: dead_low_of = DZ_SMALL;
         2'h1: dead_low_of = DZ_SMALL;
         2'h2: dead_low_of = DZ_MED_LOW;
         default: dead_low_of = DZ_LARGE_LOW;
      endcase
   endfunction

   function automatic logic [7:0] dead_high_of(input logic [1:0] code);
      case (code)
         2'h0: dead_high_of = DZ_SMALL;
         2'h1: dead_high_of = DZ_LOW_HIGH;
         2'h2: dead_high_of = DZ_MED_HIGH;
         default: dead_high_of = DZ_LARGE_HIGH;
      endcase
   endfunction
endpackage

/* core/sample_window.sv */
`timescale 1ns/1ps
`default_nettype none
module sample_window #(
   parameter int SAMPLE_W = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sample_valid,
   input wire logic [SAMPLE_W-1:0] sample,
   input wire logic restart,
   input wire logic [5:0] skip_len,
   input wire logic [2:0] avg_shift,
   output logic avg_valid,
   output logic [SAMPLE_W-1:0] avg
);
   gain_loop_pkg::window_state_type state_reg;
   logic [5:0] cnt_reg;
   logic [SAMPLE_W+5:0] accum_reg;
   logic [5:0] skip_m1;
   logic [5:0] len_m1;
   logic [SAMPLE_W+5:0] sum;
   logic last_skip;
   logic last_acc;

   assign skip_m1 = 6'(skip_len - 6'h01);
   assign len_m1 = 6'((7'h01 << avg_shift) - 7'h01);
   assign sum = accum_reg + {6'h00, sample};
   // compare with >= so a length change mid-window cannot run the counter past the end
   assign last_skip = (cnt_reg >= skip_m1);
   assign last_acc = (cnt_reg >= len_m1);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_reg <= gain_loop_pkg::WIN_SKIP;
         cnt_reg <= 6'h00;
      end else if (restart) begin
         state_reg <= gain_loop_pkg::WIN_SKIP;
         cnt_reg <= 6'h00;
      end else if (sample_valid) begin
         case (state_reg)
            gain_loop_pkg::WIN_SKIP: begin
               if (last_skip) begin
                  state_reg <= gain_loop_pkg::WIN_ACCUM;
                  cnt_reg <= 6'h00;
               end else begin
                  cnt_reg <= 6'(cnt_reg + 6'h01);
               end
            end
            gain_loop_pkg::WIN_ACCUM: begin
               if (last_acc) begin
                  cnt_reg <= 6'h00;
               end else begin
                  cnt_reg <= 6'(cnt_reg + 6'h01);
               end
            end
            default: begin
               state_reg <= gain_loop_pkg::WIN_SKIP;
               cnt_reg <= 6'h00;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         accum_reg <= '0;
      end else if (restart) begin
         accum_reg <= '0;
      end else if (sample_valid && state_reg == gain_loop_pkg::WIN_ACCUM) begin
         accum_reg <= last_acc ? '0 : sum;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         avg_valid <= 1'b0;
         avg <= '0;
      end else begin
         avg_valid <= sample_valid && !restart && state_reg == gain_loop_pkg::WIN_ACCUM && last_acc;
         if (sample_valid && state_reg == gain_loop_pkg::WIN_ACCUM && last_acc) begin
            avg <= SAMPLE_W'(sum >> avg_shift);
         end
      end
   end

   skip_end_a: assert property (@(posedge clk) disable iff (!rst_n)
      state_reg == gain_loop_pkg::WIN_SKIP && sample_valid && !restart && last_skip
      |=> state_reg == gain_loop_pkg::WIN_ACCUM) else $error("skip window did not end");
   skip_early_a: assert property (@(posedge clk) disable iff (!rst_n)
      state_reg == gain_loop_pkg::WIN_SKIP && !last_skip |=> state_reg == gain_loop_pkg::WIN_SKIP)
      else $error("skip window ended early");
   avg_len_a: assert property (@(posedge clk) disable iff (!rst_n)
      avg_valid |-> $past(cnt_reg) == $past(len_m1) && $past(state_reg) == gain_loop_pkg::WIN_ACCUM)
      else $error("average produced at wrong length");
endmodule
`default_nettype wire

/* core/receiver_gain_loop_control.sv */
`timescale 1ns/1ps
`default_nettype none
module receiver_gain_loop_control #(
   parameter int SAMPLE_W = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [5:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   output logic [7:0] reg_rdata,
   input wire logic filt_valid,
   input wire logic [SAMPLE_W-1:0] filt_magnitude,
   input wire logic [SAMPLE_W-1:0] magnitude_target,
   input wire logic ook_mode,
   input wire logic sync_found,
   input wire logic rx_restart,
   input wire logic manual_load,
   input wire logic [2:0] manual_analog,
   input wire logic [2:0] manual_digital,
   output logic [2:0] analog_gain,
   output logic [2:0] digital_gain,
   output logic gain_step,
   output logic [4:0] decision_boundary_db
);
   logic [7:0] gain_loop_control_0_reg;
   logic [1:0] deviation_hysteresis_level;
   logic [1:0] wait_code;
   logic [1:0] gain_hold_select;
   logic [1:0] len_code;
   logic sync_held_reg;
   logic [2:0] analog_gain_reg;
   logic [2:0] digital_gain_reg;
   logic [2:0] analog_next;
   logic [2:0] digital_next;
   logic step_next;
   logic avg_valid;
   logic [SAMPLE_W-1:0] avg;
   logic signed [SAMPLE_W:0] deviation;
   logic signed [SAMPLE_W:0] dz_low;
   logic signed [SAMPLE_W:0] dz_high;
   logic want_up;
   logic want_down;
   logic analog_ok;
   logic digital_ok;
   logic [2:0] avg_shift;

   assign deviation_hysteresis_level = gain_loop_pkg::field2(gain_loop_control_0_reg,
      gain_loop_pkg::HYST_LSB);
   assign wait_code = gain_loop_pkg::field2(gain_loop_control_0_reg, gain_loop_pkg::WAIT_LSB);
   assign gain_hold_select = gain_loop_pkg::field2(gain_loop_control_0_reg,
      gain_loop_pkg::HOLD_LSB);
   assign len_code = gain_loop_pkg::field2(gain_loop_control_0_reg, gain_loop_pkg::LEN_LSB);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         gain_loop_control_0_reg <= gain_loop_pkg::GAIN_LOOP_CONTROL_0_RESET;
      end else if (reg_we && reg_addr == gain_loop_pkg::GAIN_LOOP_CONTROL_0_ADDR) begin
         gain_loop_control_0_reg <= reg_wdata;
      end
   end

   // unmapped addresses read as zero
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_re) begin
         reg_rdata <= (reg_addr == gain_loop_pkg::GAIN_LOOP_CONTROL_0_ADDR) ?
            gain_loop_control_0_reg : 8'h00;
      end
   end

   // the length field means decision boundary in ook, so averaging falls back to a fixed length
   assign avg_shift = ook_mode ? gain_loop_pkg::OOK_AVG_SHIFT :
      gain_loop_pkg::avg_shift_of(len_code);

   sample_window #(
      .SAMPLE_W(SAMPLE_W)
   ) window_inst (
      .clk(clk),
      .rst_n(rst_n),
      .sample_valid(filt_valid),
      .sample(filt_magnitude),
      .restart(step_next),
      .skip_len(gain_loop_pkg::skip_len_of(wait_code)),
      .avg_shift(avg_shift),
      .avg_valid(avg_valid),
      .avg(avg)
   );

   assign deviation = $signed({1'b0, avg}) - $signed({1'b0, magnitude_target});
   assign dz_low = $signed({1'b0, gain_loop_pkg::dead_low_of(deviation_hysteresis_level)});
   assign dz_high = $signed({1'b0, gain_loop_pkg::dead_high_of(deviation_hysteresis_level)});
   assign want_up = (deviation < -dz_low);
   assign want_down = (deviation > dz_high);

   // sync hold ends only at rx_restart; a sync in the same cycle wins
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sync_held_reg <= 1'b0;
      end else if (sync_found && gain_hold_select == gain_loop_pkg::HOLD_SYNC) begin
         sync_held_reg <= 1'b1;
      end else if (rx_restart) begin
         sync_held_reg <= 1'b0;
      end
   end

   assign analog_ok = (gain_hold_select == gain_loop_pkg::HOLD_NONE) ||
      (gain_hold_select == gain_loop_pkg::HOLD_SYNC && !sync_held_reg);
   assign digital_ok = analog_ok || gain_hold_select == gain_loop_pkg::HOLD_ANALOG;

   always_comb begin
      analog_next = analog_gain_reg;
      digital_next = digital_gain_reg;
      step_next = 1'b0;
      if (gain_hold_select == gain_loop_pkg::HOLD_BOTH && manual_load) begin
         analog_next = manual_analog;
         digital_next = manual_digital;
         step_next = 1'b1;
      end else if (avg_valid && want_down) begin
         if (analog_ok && analog_gain_reg != 3'h0) begin
            analog_next = 3'(analog_gain_reg - 3'h1);
            step_next = 1'b1;
         end else if (digital_ok && digital_gain_reg != 3'h0) begin
            digital_next = 3'(digital_gain_reg - 3'h1);
            step_next = 1'b1;
         end
      end else if (avg_valid && want_up) begin
         if (analog_ok && analog_gain_reg != gain_loop_pkg::GAIN_MAX) begin
            analog_next = 3'(analog_gain_reg + 3'h1);
            step_next = 1'b1;
         end else if (digital_ok && digital_gain_reg != gain_loop_pkg::GAIN_MAX) begin
            digital_next = 3'(digital_gain_reg + 3'h1);
            step_next = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         analog_gain_reg <= gain_loop_pkg::GAIN_RESET;
         digital_gain_reg <= gain_loop_pkg::GAIN_RESET;
         gain_step <= 1'b0;
      end else begin
         analog_gain_reg <= analog_next;
         digital_gain_reg <= digital_next;
         gain_step <= step_next;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         decision_boundary_db <= gain_loop_pkg::boundary_db_of(
            gain_loop_pkg::field2(gain_loop_pkg::GAIN_LOOP_CONTROL_0_RESET,
            gain_loop_pkg::LEN_LSB));
      end else begin
         decision_boundary_db <= gain_loop_pkg::boundary_db_of(len_code);
      end
   end

   assign analog_gain = analog_gain_reg;
   assign digital_gain = digital_gain_reg;

   dead_zone_a: assert property (@(posedge clk) disable iff (!rst_n)
      avg_valid && !manual_load && deviation >= -dz_low && deviation <= dz_high
      |=> !gain_step && $stable(analog_gain_reg) && $stable(digital_gain_reg))
      else $error("gain moved inside dead zone");
   free_adjust_a: assert property (@(posedge clk) disable iff (!rst_n)
      gain_hold_select == gain_loop_pkg::HOLD_NONE && avg_valid && want_down
      && analog_gain_reg != 3'h0 |=> analog_gain_reg == $past(analog_gain_reg) - 3'h1)
      else $error("free loop did not lower gain");
   raise_first_a: assert property (@(posedge clk) disable iff (!rst_n)
      gain_hold_select == gain_loop_pkg::HOLD_NONE && avg_valid && want_up
      && analog_gain_reg != gain_loop_pkg::GAIN_MAX
      |=> analog_gain_reg == 3'($past(analog_gain_reg) + 3'h1) && $stable(digital_gain_reg))
      else $error("free loop did not raise analogue gain");
   lower_digital_a: assert property (@(posedge clk) disable iff (!rst_n)
      gain_hold_select == gain_loop_pkg::HOLD_NONE && avg_valid && want_down
      && analog_gain_reg == 3'h0 && digital_gain_reg != 3'h0
      |=> digital_gain_reg == 3'($past(digital_gain_reg) - 3'h1))
      else $error("digital gain not lowered at analogue limit");
   sync_set_a: assert property (@(posedge clk) disable iff (!rst_n)
      sync_found && gain_hold_select == gain_loop_pkg::HOLD_SYNC |=> sync_held_reg)
      else $error("sync did not hold gain");
   sync_release_a: assert property (@(posedge clk) disable iff (!rst_n)
      rx_restart && !sync_found |=> !sync_held_reg)
      else $error("restart did not release sync hold");
   sync_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      gain_hold_select == gain_loop_pkg::HOLD_SYNC && sync_held_reg
      |=> $stable(analog_gain_reg) && $stable(digital_gain_reg))
      else $error("gain moved after sync");
   analog_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      gain_hold_select == gain_loop_pkg::HOLD_ANALOG |=> $stable(analog_gain_reg))
      else $error("analogue gain moved while held");
   digital_run_a: assert property (@(posedge clk) disable iff (!rst_n)
      gain_hold_select == gain_loop_pkg::HOLD_ANALOG && avg_valid
      && ((want_up && digital_gain_reg != gain_loop_pkg::GAIN_MAX)
      || (want_down && digital_gain_reg != 3'h0)) |=> gain_step && $changed(digital_gain_reg))
      else $error("digital gain not adjusted");
   both_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      gain_hold_select == gain_loop_pkg::HOLD_BOTH && !manual_load
      |=> $stable(analog_gain_reg) && $stable(digital_gain_reg))
      else $error("gain moved while fully held");
   manual_load_a: assert property (@(posedge clk) disable iff (!rst_n)
      gain_hold_select == gain_loop_pkg::HOLD_BOTH && manual_load
      |=> analog_gain_reg == $past(manual_analog) && digital_gain_reg == $past(manual_digital))
      else $error("manual gain not applied");
   avg_shift_a: assert property (@(posedge clk) disable iff (!rst_n)
      !ook_mode |-> avg_shift == 3'(3'h3 + {1'b0, len_code}))
      else $error("averaging length wrong");
   boundary_a: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1 |=> decision_boundary_db == 5'(5'h04 * ({3'h0, $past(len_code)} + 5'h01)))
      else $error("decision boundary wrong");
   reg_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      reg_we && reg_addr == gain_loop_pkg::GAIN_LOOP_CONTROL_0_ADDR
      |=> gain_loop_control_0_reg == $past(reg_wdata))
      else $error("register write lost");
   read_data_a: assert property (@(posedge clk) disable iff (!rst_n)
      reg_re && reg_addr == gain_loop_pkg::GAIN_LOOP_CONTROL_0_ADDR
      |=> reg_rdata == $past(gain_loop_control_0_reg))
      else $error("register read wrong");
   unmapped_read_a: assert property (@(posedge clk) disable iff (!rst_n)
      reg_re && reg_addr != gain_loop_pkg::GAIN_LOOP_CONTROL_0_ADDR |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule
`default_nettype wire

/* verification/gain_stage_model.sv */
`timescale 1ns/1ps
`default_nettype none
// stands in for the receive chain: emits a burst of channel-filter samples
module gain_stage_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic go,
   input wire logic [7:0] burst_len,
   input wire logic [3:0] gap,
   input wire logic [7:0] level,
   input wire logic [7:0] dither,
   output logic busy,
   output logic filt_valid,
   output logic [7:0] filt_magnitude
);
   logic [7:0] left_reg = 8'h00;
   logic [3:0] tick_reg = 4'h0;
   logic valid_reg = 1'b0;
   logic [7:0] mag_reg = 8'h00;
   assign busy = (left_reg != 8'h00);
   assign filt_valid = valid_reg;
   assign filt_magnitude = mag_reg;
   always @(posedge clk) begin
      if (!rst_n) begin
         left_reg <= 8'h00;
         tick_reg <= 4'h0;
         valid_reg <= 1'b0;
      end else if (go) begin
         left_reg <= burst_len;
         tick_reg <= 4'h0;
         valid_reg <= 1'b0;
      end else if (busy && tick_reg == 4'h0) begin
         left_reg <= left_reg - 8'h01;
         tick_reg <= gap - 4'h1;
         valid_reg <= 1'b1;
         mag_reg <= level + (8'($urandom) & dither);
      end else begin
         tick_reg <= (tick_reg == 4'h0) ? 4'h0 : tick_reg - 4'h1;
         valid_reg <= 1'b0;
         // no held value between samples, so a stale magnitude cannot pass
         mag_reg <= ~mag_reg;
      end
   end
endmodule
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [5:0] reg_addr = 6'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_we = 1'b0;
   logic reg_re = 1'b0;
   logic [7:0] reg_rdata;
   logic filt_valid;
   logic [7:0] filt_magnitude;
   logic ook_mode = 1'b0;
   logic sync_found = 1'b0;
   logic rx_restart = 1'b0;
   logic manual_load = 1'b0;
   logic [2:0] manual_analog = 3'h0;
   logic [2:0] manual_digital = 3'h0;
   logic [2:0] analog_gain;
   logic [2:0] digital_gain;
   logic gain_step;
   logic [4:0] decision_boundary_db;
   logic go = 1'b0;
   logic busy;
   logic [7:0] burst_len = 8'h00;
   logic [3:0] gap = 4'h4;
   logic [7:0] level = 8'h60;
   logic [7:0] dither = 8'h00;
   logic re_d1 = 1'b0;
   logic re_d2 = 1'b0;
   logic [2:0] ea = 3'h7;
   logic [2:0] ed = 3'h7;
   logic [7:0] hi [4] = '{8'h02, 8'h04, 8'h08, 8'h10};
   logic [7:0] rd_q[$];
   logic [5:0] gain_q[$];
   int cnt_q[$];
   int cnt = 0;
   int bad_count = 0;
   int n_compared = 0;
   always #4 clk = ~clk;
   receiver_gain_loop_control receiver_gain_loop_control_i (.clk(clk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
      .reg_rdata(reg_rdata), .filt_valid(filt_valid), .filt_magnitude(filt_magnitude),
      .magnitude_target(8'h40), .ook_mode(ook_mode), .sync_found(sync_found),
      .rx_restart(rx_restart), .manual_load(manual_load), .manual_analog(manual_analog),
      .manual_digital(manual_digital), .analog_gain(analog_gain),
      .digital_gain(digital_gain), .gain_step(gain_step),
      .decision_boundary_db(decision_boundary_db));
   gain_stage_model gain_stage_model_i (.clk(clk), .rst_n(rst_n), .go(go),
      .burst_len(burst_len), .gap(gap), .level(level), .dither(dither), .busy(busy),
      .filt_valid(filt_valid), .filt_magnitude(filt_magnitude));
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_we <= 1'b1;
      @(posedge clk);
      reg_we <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] exp);
      rd_q.push_back(exp);
      reg_addr <= a;
      reg_re <= 1'b1;
      @(posedge clk);
      reg_re <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic db(input logic [7:0] exp);
      @(negedge clk);
      check("boundary_db", {3'h0, decision_boundary_db}, exp);
      @(posedge clk);
   endtask
   task automatic down;
      if (ea != 3'h0) begin
         ea = ea - 3'h1;
      end else begin
         ed = ed - 3'h1;
      end
   endtask
   task automatic run(input int n, input int c, input logic [7:0] lvl, input bit exp);
      if (exp) begin
         cnt_q.push_back(c);
         gain_q.push_back({ea, ed});
      end
      level <= lvl;
      burst_len <= 8'(n);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      for (int k = 0; k < 2000 && busy; k++) @(posedge clk);
      repeat (6) @(posedge clk);
      check("pending_steps", 8'(cnt_q.size()), 8'h00);
   endtask
   always @(posedge clk) begin
      re_d1 <= reg_re;
      re_d2 <= re_d1;
      if (filt_valid === 1'b1) cnt <= cnt + 1;
   end
   always @(negedge clk) begin
      int c;
      logic [5:0] g;
      if (re_d2) check("reg_rdata", reg_rdata, rd_q.pop_front());
      if (gain_step === 1'b1) begin
         if (cnt_q.size() == 0) begin
            check("gain_step", 8'h01, 8'h00);
         end else begin
            c = cnt_q.pop_front();
            g = gain_q.pop_front();
            if (c >= 0) check("samples", 8'(cnt), 8'(c));
            check("analog_gain", {5'h0, analog_gain}, {5'h0, g[5:3]});
            check("digital_gain", {5'h0, digital_gain}, {5'h0, g[2:0]});
         end
         cnt <= 0;
      end
   end
   // budget of 60000 cycles is over twenty times the expected run of about 2600 cycles
   initial begin
      #(8 * 60000);
      bad_count++;
      wrap_up();
   end
   initial begin
      logic [7:0] r;
      r = 8'($urandom(52660));
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      db(8'h08);
      rd(6'h1d, 8'h91);
      rd(6'h05, 8'h00);
      wr(6'h05, r);
      rd(6'h1d, 8'h91);
      r = 8'($urandom);
      wr(6'h1d, r);
      rd(6'h1d, r);
      for (int k = 0; k < 4; k++) begin
         wr(6'h1d, {6'h00, 2'(k)});
         db(8'(4 * (k + 1)));
      end
      dither <= 8'h1f;
      for (int w = 0; w < 4; w++) begin
         gap <= 4'(4 + 2 * (w & 1));
         wr(6'h1d, {2'h0, 2'(w), 2'h0, 2'(3 - w)});
         down();
         run(8 * (w + 1) + (8 << (3 - w)), 8 * (w + 1) + (8 << (3 - w)), 8'h60, 1);
      end
      ook_mode <= 1'b1;
      wr(6'h1d, 8'h13);
      down();
      run(24, 24, 8'h60, 1);
      db(8'h10);
      ook_mode <= 1'b0;
      wr(6'h1d, 8'h08);
      ed = ed - 3'h1;
      run(16, 16, 8'h60, 1);
      wr(6'h1d, 8'h0c);
      run(16, -1, 8'h60, 0);
      manual_analog <= 3'h4 + 3'($urandom & 3);
      manual_digital <= 3'($urandom);
      manual_load <= 1'b1;
      @(posedge clk);
      manual_load <= 1'b0;
      ea = manual_analog;
      ed = manual_digital;
      cnt_q.push_back(-1);
      gain_q.push_back({ea, ed});
      repeat (4) @(posedge clk);
      dither <= 8'h00;
      for (int h = 0; h < 4; h++) begin
         wr(6'h1d, {2'(h), 6'h00});
         run(16, -1, 8'h40 + hi[h], 0);
         down();
         run(8, 24, 8'h41 + hi[h], 1);
      end
      run(16, -1, 8'h38, 0);
      ea = ea + 3'h1;
      run(8, 24, 8'h37, 1);
      wr(6'h1d, 8'h14);
      sync_found <= 1'b1;
      @(posedge clk);
      sync_found <= 1'b0;
      run(24, -1, 8'h60, 0);
      rx_restart <= 1'b1;
      @(posedge clk);
      rx_restart <= 1'b0;
      down();
      run(24, -1, 8'h60, 1);
      wrap_up();
   end
endmodule
`default_nettype wire
